// ---- src/fsg_pkg.sv ----
// Shared constants and types of the frame statistics and pixel grab block
package fsg_pkg;

  // ****************************************************
  // Data widths
  // ****************************************************
  localparam int unsigned DataW = 8;
  localparam int unsigned AddrW = 8;
  localparam int unsigned IdxW = 9;
  localparam int unsigned SumW = 17;
  localparam int unsigned SumShift = 9;
  localparam int unsigned FifoDepth = 16;
  localparam int unsigned TestCntW = 23;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] AddrMotion = 8'h02;
  localparam logic [7:0] AddrFrameTotal = 8'h09;
  localparam logic [7:0] AddrLowestLevel = 8'h0a;
  localparam logic [7:0] AddrGrabReadout = 8'h0b;
  localparam logic [7:0] AddrResultByte0 = 8'h0c;
  localparam logic [7:0] AddrSelftest = 8'h10;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int unsigned ReadyFlagBit = 0;
  localparam int unsigned FirstFlagBit = 1;
  localparam int unsigned TriggerBit = 0;

  // ****************************************************
  // Array geometry and value limits
  // ****************************************************
  localparam logic [8:0] LastPixAddr = 9'h168;
  localparam logic [8:0] FirstPixAddr = 9'h000;
  localparam logic [7:0] TotalMax = 8'hf0;
  localparam logic [7:0] LowestMax = 8'hfe;
  localparam logic [7:0] LowestInit = 8'hff;
  localparam logic [7:0] ResultReset = 8'h00;
  localparam logic [7:0] ReadZero = 8'h00;
  localparam logic [7:0] SigSeed = 8'h01;
  localparam logic [7:0] SigPoly = 8'h1d;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned ClkKhz = 25000;
  localparam int unsigned SelftestMs = 250;
  localparam int unsigned SelftestCycles = SelftestMs * ClkKhz;

  // ****************************************************
  // State enumerations
  // ****************************************************
  typedef enum logic [1:0] {
    GrabIdle,
    GrabWait,
    GrabArmed,
    GrabHeld
  } fsg_grab_type;

  typedef enum logic {
    TestOff,
    TestRun
  } fsg_test_type;

endpackage

// ---- src/fsg_fifo.sv ----
// Pixel stream FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fsg_fifo #(
  parameter int unsigned Width = 9,
  parameter int unsigned Depth = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Filling side
  input wire logic inValid,
  input wire logic [Width-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [Width-1:0] outData,
  input wire logic outReady
);

  localparam int unsigned PtrW = $clog2(Depth);

  typedef struct packed {
    logic [Depth-1:0][Width-1:0] mem;
    logic [PtrW-1:0] wrPtr;
    logic [PtrW-1:0] rdPtr;
    logic [PtrW:0] count;
    logic inRdy;
  } fsg_fifo_state_type;

  localparam fsg_fifo_state_type FifoReset = '{
    mem: '0, wrPtr: '0, rdPtr: '0, count: '0, inRdy: 1'b1};

  fsg_fifo_state_type s_q;
  fsg_fifo_state_type s_d;
  logic push;
  logic pop;

  assign inReady = s_q.inRdy;
  assign outValid = (s_q.count != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign push = inValid & s_q.inRdy;
  assign pop = outValid & outReady;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = s_q.wrPtr + PtrW'(1);
    end
    if (pop) begin
      s_d.rdPtr = s_q.rdPtr + PtrW'(1);
    end
    if (push && !pop) begin
      s_d.count = s_q.count + (PtrW+1)'(1);
    end else if (pop && !push) begin
      s_d.count = s_q.count - (PtrW+1)'(1);
    end
    // Registered ready keeps the source path free of logic
    s_d.inRdy = (s_d.count != (PtrW+1)'(Depth));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= FifoReset;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ---- src/fsg_top.sv ----
// Frame statistics, pixel grab readout and self-test result registers
`timescale 1ns/1ps
// Summary of operation
// - Total is sum bits 16..9 per frame
// - Total clamped to 240, updated each frame
// - Offset 0x0a holds frame lowest pixel, clamped to 254
// - Grab delivers one pixel per frame
// - Grab write resets pointer, starts grab
// - Ready set only with valid grab value
// - Grab read of a held value advances pointer by one
// - After full array, wrap and flag first
// - Pointer spans 19x19, addresses 0..360
// - Lens view mirrors the same addressing
// - Result byte at 0x0c resets to zero
// - Result byte comes from self-test run
// - First flag set on write or wrap
// - Self-test runs 250 ms, bus ignored
module fsg_top
  import fsg_pkg::*;
#(
  parameter int unsigned TestCycles = SelftestCycles,
  parameter int unsigned BufDepth = FifoDepth
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pixel stream from the image array
  input wire logic pixValid,
  input wire logic [DataW-1:0] pixData,
  input wire logic grab_first_location_flag,
  output logic pixReady,
  // Register port
  input wire logic [AddrW-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DataW-1:0] regWdata,
  output logic [DataW-1:0] regRdata,
  output logic regRdValid,
  // Status
  output logic selftestBusy
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [IdxW-1:0] pixIdx;
    logic frameOpen;
    logic [SumW-1:0] sum;
    logic [DataW-1:0] low;
    logic [DataW-1:0] total;
    logic [DataW-1:0] lowest;
    fsg_grab_type grab;
    logic [IdxW-1:0] grabPtr;
    logic [DataW-1:0] grabValue;
    logic grabFirst;
    fsg_test_type test;
    logic busy;
    logic [TestCntW-1:0] testCnt;
    logic [DataW-1:0] sig;
    logic [DataW-1:0] result0;
    logic [DataW-1:0] rdData;
    logic rdValid;
  } fsg_top_state_type;

  localparam fsg_top_state_type TopReset = '{
    pixIdx: '0,
    frameOpen: 1'b0,
    sum: '0,
    low: LowestInit,
    total: '0,
    lowest: '0,
    grab: GrabIdle,
    grabPtr: '0,
    grabValue: '0,
    grabFirst: 1'b0,
    test: TestOff,
    busy: 1'b0,
    testCnt: '0,
    sig: SigSeed,
    result0: ResultReset,
    rdData: '0,
    rdValid: 1'b0
  };

  // Compare one early: busy then lasts TestCycles edges
  localparam logic [TestCntW-1:0] TestLast = TestCntW'(TestCycles - 1);

  fsg_top_state_type s_q;
  fsg_top_state_type s_d;

  // ****************************************************
  // Input buffering
  // ****************************************************
  logic bufValid;
  logic [DataW:0] bufData;
  logic drainReady;

  // Frame-start mark travels with each pixel
  fsg_fifo #(
    .Width(DataW + 1),
    .Depth(BufDepth)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inValid(pixValid),
    .inData({grab_first_location_flag, pixData}),
    .inReady(pixReady),
    .outValid(bufValid),
    .outData(bufData),
    .outReady(drainReady)
  );

  // Array readout is frozen while the self-test owns the datapath
  assign drainReady = (s_q.test == TestOff);

  // ****************************************************
  // Next-state logic
  // ****************************************************
  logic pop;
  logic frameStart;
  logic [DataW-1:0] pixVal;
  logic [IdxW-1:0] idxNext;
  logic [SumW-1:0] sumNext;
  logic [DataW-1:0] lowNext;
  logic [DataW-1:0] totalRaw;
  logic busAccess;
  logic grabWrite;
  logic grabRead;

  assign pop = bufValid & drainReady;
  assign frameStart = pop & bufData[DataW];
  assign pixVal = bufData[DataW-1:0];
  assign busAccess = ~s_q.busy;
  assign grabWrite = busAccess & regWrite & (regAddr == AddrGrabReadout);
  assign grabRead = busAccess & regRead & (regAddr == AddrGrabReadout);

  // ****************************************************
  // Access and frame qualifiers
  // ****************************************************
  logic testWrite;
  logic readAccept;
  logic pixCounted;

  assign testWrite = busAccess & regWrite & (regAddr == AddrSelftest) &
    regWdata[TriggerBit];
  assign readAccept = busAccess & regRead;
  // Stray words outside an open frame are neither summed nor grabbed
  assign pixCounted = pop & (bufData[DataW] | s_q.frameOpen);

  always_comb begin
    s_d = s_q;
    idxNext = s_q.pixIdx;
    sumNext = s_q.sum;
    lowNext = s_q.low;
    totalRaw = '0;
    // Read answer is a one-cycle pulse
    s_d.rdValid = 1'b0;

    // **************************************************
    // Frame statistics
    // **************************************************
    if (pixCounted) begin
      // raster index 0..360 of 19x19 array
      if (frameStart) begin
        // First word opens a new frame
        idxNext = FirstPixAddr;
        sumNext = SumW'(pixVal);
        lowNext = pixVal;
      end else begin
        idxNext = s_q.pixIdx + IdxW'(1);
        sumNext = s_q.sum + SumW'(pixVal);
        lowNext = (pixVal < s_q.low) ? pixVal : s_q.low;
      end
      s_d.pixIdx = idxNext;
      s_d.sum = sumNext;
      s_d.low = lowNext;
      // Frame closes on its last pixel
      s_d.frameOpen = (idxNext != LastPixAddr);
      if (idxNext == LastPixAddr) begin
        // Statistics refresh once per complete frame
        // keep the high eight of the sum
        totalRaw = sumNext[SumW-1:SumShift];
        s_d.total = (totalRaw > TotalMax) ? TotalMax : totalRaw;
        s_d.lowest = (lowNext > LowestMax) ? LowestMax : lowNext;
      end
    end

    // **************************************************
    // Pixel grab
    // **************************************************
    case (s_q.grab)
      GrabIdle: begin
        // No grab until the first restart write
        s_d.grab = GrabIdle;
      end
      GrabWait: begin
        // wait for a fresh frame before capture
        if (frameStart) begin
          if (idxNext == s_q.grabPtr) begin
            s_d.grabValue = pixVal;
            s_d.grab = GrabHeld;
          end else begin
            // Pointer lies later in this frame
            s_d.grab = GrabArmed;
          end
        end
      end
      GrabArmed: begin
        // same address order seen through lens
        if (pixCounted && idxNext == s_q.grabPtr) begin
          s_d.grabValue = pixVal;
          s_d.grab = GrabHeld;
        end
      end
      GrabHeld: begin
        // Ready stands until read or restart; value stays until next capture
        // read steps to the next pixel
        if (grabRead) begin
          s_d.grab = GrabWait;
          // wrap after full array, flag first
          if (s_q.grabPtr == LastPixAddr) begin
            s_d.grabPtr = FirstPixAddr;
            s_d.grabFirst = 1'b1;
          end else begin
            s_d.grabPtr = s_q.grabPtr + IdxW'(1);
            s_d.grabFirst = 1'b0;
          end
        end
      end
      default: begin
        s_d.grab = GrabIdle;
      end
    endcase

    // **************************************************
    // Grab restart
    // **************************************************
    // Write wins over a same-cycle capture or read
    // any write restarts the grab at 0,0
    if (grabWrite) begin
      s_d.grab = GrabWait;
      s_d.grabPtr = FirstPixAddr;
      s_d.grabFirst = 1'b1;
    end

    // **************************************************
    // Self-test
    // **************************************************
    case (s_q.test)
      TestOff: begin
        if (testWrite) begin
          s_d.test = TestRun;
          s_d.busy = 1'b1;
          s_d.testCnt = '0;
          // Fresh seed so every run gives the same byte
          s_d.sig = SigSeed;
        end
      end
      TestRun: begin
        // Signature LFSR advances once per cycle
        s_d.sig = {s_q.sig[DataW-2:0], 1'b0} ^
          (s_q.sig[DataW-1] ? SigPoly : ReadZero);
        if (s_q.testCnt == TestLast) begin
          s_d.test = TestOff;
          s_d.busy = 1'b0;
          // Value from before the final step
          // result byte updated only here
          s_d.result0 = s_q.sig;
        end else begin
          s_d.testCnt = s_q.testCnt + TestCntW'(1);
        end
      end
      default: begin
        s_d.test = TestOff;
        s_d.busy = 1'b0;
      end
    endcase

    // **************************************************
    // Register reads
    // **************************************************
    // accesses during the test are dropped
    // Data holds until the next accepted read
    if (readAccept) begin
      s_d.rdValid = 1'b1;
      s_d.rdData = ReadZero;
      case (regAddr)
        AddrMotion: begin
          // Spare bits read as zero
          // host polls this ready flag
          s_d.rdData[ReadyFlagBit] = (s_q.grab == GrabHeld);
          s_d.rdData[FirstFlagBit] = s_q.grabFirst;
        end
        AddrFrameTotal: begin
          s_d.rdData = s_q.total;
        end
        AddrLowestLevel: begin
          s_d.rdData = s_q.lowest;
        end
        AddrGrabReadout: begin
          s_d.rdData = s_q.grabValue;
        end
        AddrResultByte0: begin
          s_d.rdData = s_q.result0;
        end
        default: begin
          // Unmapped offsets answer zero
          s_d.rdData = ReadZero;
        end
      endcase
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= TopReset;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Every output comes straight from a state flop
  assign regRdata = s_q.rdData;
  assign regRdValid = s_q.rdValid;
  assign selftestBusy = s_q.busy;

endmodule

// ---- tb/fsg_checker.sv ----
// Port assertions for the frame statistics and grab block
`timescale 1ns/1ps
module fsg_checker
  import fsg_pkg::*;
#(
  parameter int unsigned TestCycles = SelftestCycles
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic pixValid,
  input wire logic [DataW-1:0] pixData,
  input wire logic grab_first_location_flag,
  input wire logic pixReady,
  input wire logic [AddrW-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DataW-1:0] regWdata,
  input wire logic [DataW-1:0] regRdata,
  input wire logic regRdValid,
  input wire logic selftestBusy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int unsigned busyCnt_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt_q <= 0;
    end else begin
      busyCnt_q <= selftestBusy ? busyCnt_q + 1 : 0;
    end
  end
  chk_read_answer: assert property (
    regRead && !selftestBusy |=> regRdValid) else $error("read lost");
  chk_answer_cause: assert property (
    regRdValid |-> $past(regRead) && !$past(selftestBusy))
    else $error("answer without read");
  chk_busy_refuse: assert property (
    selftestBusy && regRead |=> !regRdValid) else $error("busy read");
  chk_test_start: assert property (
    regWrite && regAddr == AddrSelftest && regWdata[TriggerBit]
    && !selftestBusy |=> selftestBusy) else $error("test not started");
  chk_test_length: assert property (
    $fell(selftestBusy) |-> busyCnt_q == TestCycles)
    else $error("test length wrong");
  chk_total_range: assert property (
    regRdValid && $past(regAddr) == AddrFrameTotal |-> regRdata <= TotalMax)
    else $error("total out of range");
  chk_lowest_range: assert property (
    regRdValid && $past(regAddr) == AddrLowestLevel
    |-> regRdata <= LowestMax) else $error("lowest out of range");
  chk_motion_bits: assert property (
    regRdValid && $past(regAddr) == AddrMotion |-> regRdata[7:2] == 6'h00)
    else $error("motion spare bits set");
  chk_data_hold: assert property (
    !regRdValid |-> $stable(regRdata)) else $error("read data moved");
  cov_read: cover property (regRdValid && $past(regAddr) == AddrGrabReadout);
  cov_test: cover property ($fell(selftestBusy));
  cov_full: cover property ($fell(pixReady));
endmodule
bind fsg_top fsg_checker #(.TestCycles(TestCycles)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .pixValid(pixValid),
  .pixData(pixData), .grab_first_location_flag(grab_first_location_flag), .pixReady(pixReady),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
  .selftestBusy(selftestBusy));

// ---- tb/fsg_pix_src.sv ----
// Image array model streaming one frame of pixels
`timescale 1ns/1ps
module fsg_pix_src
  import fsg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Frame request
  input wire logic frameGo,
  input wire logic [7:0] val,
  input wire logic [8:0] lowAt,
  input wire logic [7:0] lowVal,
  output logic srcBusy,
  // Pixel stream
  input wire logic pixReady,
  output logic pixValid,
  output logic [7:0] pixData,
  output logic grab_first_location_flag
);
  logic [8:0] addr;
  logic [7:0] noise;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      srcBusy <= 1'b0;
      addr <= 9'h000;
      noise <= 8'h00;
    end else begin
      noise <= noise + 8'h3b;
      if (frameGo && !srcBusy) begin
        srcBusy <= 1'b1;
        addr <= 9'h000;
      end else if (srcBusy && pixReady) begin
        srcBusy <= (addr != LastPixAddr);
        addr <= addr + 9'h001;
      end
    end
  end
  // Idle lines churn so stale data is never mistaken for a pixel
  assign pixValid = srcBusy;
  assign grab_first_location_flag = srcBusy ? (addr == 9'h000) : noise[0];
  assign pixData = !srcBusy ? noise : (addr == lowAt) ? lowVal : val;
endmodule

// ---- tb/tb_fsg_top.sv ----
// Register level testbench of the frame statistics and grab block
`timescale 1ns/1ps
module tb_fsg_top
  import fsg_pkg::*;
;
  logic ref_clk, resetn, pixValid, grab_first_location_flag, pixReady, regWrite, regRead;
  logic regRdValid, selftestBusy, frameGo, srcBusy;
  logic [7:0] pixData, regAddr, regWdata, regRdata, val, lowVal;
  logic [8:0] lowAt;
  int bad_count = 0;
  int n_tests = 0;
  localparam int unsigned TbTest = 60;
  logic [7:0] d;
  logic v;
  fsg_top #(.TestCycles(TbTest), .BufDepth(16)) u_dut (.ref_clk(ref_clk),
    .resetn(resetn), .pixValid(pixValid), .pixData(pixData),
    .grab_first_location_flag(grab_first_location_flag), .pixReady(pixReady), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regRdValid(regRdValid),
    .selftestBusy(selftestBusy));
  fsg_pix_src u_src (.ref_clk(ref_clk), .resetn(resetn),
    .frameGo(frameGo), .val(val), .lowAt(lowAt), .lowVal(lowVal),
    .srcBusy(srcBusy), .pixReady(pixReady), .pixValid(pixValid),
    .pixData(pixData), .grab_first_location_flag(grab_first_location_flag));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ****************************************************
  // Access and compare tasks
  // ****************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Seeded signature; the last step lands after the capture
  function automatic logic [7:0] sig_after(input int unsigned steps);
    logic [7:0] s;
    s = SigSeed;
    for (int unsigned i = 0; i < steps; i++) begin
      s = {s[6:0], 1'b0} ^ (s[7] ? SigPoly : 8'h00);
    end
    return s;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge ref_clk);
    regAddr = a;
    regWdata = dat;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    v = regRdValid;
    d = regRdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk1("read valid", 1'b1, v);
    chk8("read data", e, d);
  endtask
  task automatic frame(input logic [7:0] fv, input logic [8:0] at,
                       input logic [7:0] lv, input logic hold);
    int n;
    val = fv;
    lowAt = at;
    lowVal = lv;
    @(negedge ref_clk);
    frameGo = 1'b1;
    @(negedge ref_clk);
    frameGo = 1'b0;
    n = 0;
    while (!hold && srcBusy && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk1("frame sent", 1'b0, srcBusy & ~hold);
    // Let the FIFO drain before reading totals
    repeat (20) @(negedge ref_clk);
  endtask
  task automatic poll();
    int n;
    n = 0;
    do begin
      rd(AddrMotion);
      n++;
    end while (d[ReadyFlagBit] !== 1'b1 && n < 400);
    chk1("ready flag", 1'b1, d[ReadyFlagBit]);
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    frameGo = 1'b0;
    val = 8'h00;
    lowAt = 9'h000;
    lowVal = 8'h00;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    rdc(AddrResultByte0, ResultReset);
    rdc(AddrMotion, 8'h00);
    rdc(8'h20, ReadZero);
    frame(8'h64, 9'h000, 8'h07, 1'b0);
    rdc(AddrFrameTotal, 8'h46);
    rdc(AddrLowestLevel, 8'h07);
    frame(8'hff, 9'h168, 8'hff, 1'b0);
    rdc(AddrFrameTotal, 8'hb3);
    rdc(AddrLowestLevel, 8'hfe);
    wr(AddrLowestLevel, 8'haa);
    rdc(AddrLowestLevel, 8'hfe);
    wr(AddrGrabReadout, 8'h5c);
    frame(8'h32, 9'h000, 8'h09, 1'b0);
    poll();
    rdc(AddrMotion, 8'h03);
    rdc(AddrGrabReadout, 8'h09);
    rdc(AddrMotion, 8'h00);
    rdc(AddrGrabReadout, 8'h09);
    frame(8'h32, 9'h001, 8'h0b, 1'b0);
    poll();
    rdc(AddrMotion, 8'h01);
    rdc(AddrGrabReadout, 8'h0b);
    wr(AddrGrabReadout, 8'h00);
    frame(8'h32, 9'h000, 8'h0d, 1'b0);
    poll();
    rdc(AddrMotion, 8'h03);
    rdc(AddrGrabReadout, 8'h0d);
    wr(AddrSelftest, 8'h01);
    chk1("busy", 1'b1, selftestBusy);
    rd(AddrLowestLevel);
    chk1("refused read", 1'b0, v);
    frame(8'h10, 9'h000, 8'h10, 1'b1);
    chk1("fifo full", 1'b0, pixReady);
    repeat (80) @(negedge ref_clk);
    chk1("busy", 1'b0, selftestBusy);
    rd(AddrResultByte0);
    chk1("result valid", 1'b1, v);
    chk8("result byte", sig_after(TbTest - 1), d);
    // Stalled frame resumes once the test is over
    repeat (400) @(negedge ref_clk);
    rdc(AddrFrameTotal, 8'h0b);
    rdc(AddrLowestLevel, 8'h10);
    test_done();
  end
  initial begin
    #(40 * 40000);
    bad_count++;
    test_done();
  end
endmodule
